// ---- src/wbl_lane_mask.sv ----
// Purpose: Works out the active byte lanes of one beat from its address and size.
// Assumes: Size already clamped to the bus width.
// Notes:   Same formula serves unaligned first beats and aligned later beats.
module wbl_lane_mask
    import wbl_pkg::*;
(
    input  wire logic [LANE_W-1:0]     addr_lane,
    input  wire logic [1:0]            size,
    output logic      [DATA_BYTES-1:0] mask
);

    // ************************************************************
    // Lane bounds
    // ************************************************************
    // Bytes per beat less one, as a lane offset
    wire logic [2:0]        nbytes  = 3'h1 << size;
    wire logic [LANE_W-1:0] nb_m1   = LANE_W'(nbytes - 3'h1);
    // Lowest lane is the address within the bus word
    wire logic [LANE_W-1:0] low_ln  = addr_lane;
    // Highest lane is the aligned lane plus the beat size less one
    wire logic [LANE_W-1:0] high_ln = (addr_lane & ~nb_m1) + nb_m1; // R09

    // ************************************************************
    // Per-lane compare
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < DATA_BYTES; i++) begin : g_lane
            // Lane active between lowest and highest lane
            assign mask[i] = (LANE_W'(i) >= low_ln) && (LANE_W'(i) <= high_ln); // R05 R23
        end
    endgenerate

endmodule

// ---- src/wbl_pkg.sv ----
// Purpose: Shared constants and carrier types for the write byte-lane block.
// Assumes: A 32-bit write data bus, so four byte lanes, and 12-bit byte addresses.
// Notes:   Beat sizes above the bus width are clamped to the bus width.
package wbl_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int DATA_BYTES = 4;              // Byte lanes on the data bus
    localparam int DATA_W     = 8 * DATA_BYTES; // Data bus width in bits
    localparam int LANE_W     = 2;              // Bits of a lane index
    localparam int ADDR_W     = 12;             // Byte address width
    localparam int LEN_W      = 8;              // Beat count field width
    localparam int MEM_WORDS  = 64;             // Words of local storage
    localparam int WIDX_W     = 6;              // Bits of a word index
    localparam int WIDX_LSB   = 2;              // Lowest address bit of the word index

    // ************************************************************
    // Size field
    // ************************************************************
    localparam logic [2:0] SIZE_MAX = 3'h2;     // Largest size the bus carries

    // ************************************************************
    // Burst type codes
    // ************************************************************
    localparam logic [1:0] BURST_FIXED = 2'h0;  // Same address every beat
    localparam logic [1:0] BURST_INCR  = 2'h1;  // Address advances each beat
    localparam logic [1:0] BURST_WRAP  = 2'h2;  // Advances and wraps at boundary

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [ADDR_W-1:0]     RST_ADDR = 12'h000; // Beat address after reset
    localparam logic [LEN_W-1:0]      RST_LEFT = 8'h00;   // Beats left after reset
    localparam logic [DATA_BYTES-1:0] RST_MASK = 4'h0;    // Lane mask after reset
    localparam logic [DATA_W-1:0]     RST_DATA = 32'h0;   // Read data after reset

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        WBL_IDLE  = 2'h1,                       // Waiting for a burst command
        WBL_BURST = 2'h2                        // Taking write beats
    } wbl_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;                // Start address, may be unaligned
        logic [LEN_W-1:0]  len;                 // Beats minus one
        logic [2:0]        size;                // Log2 of bytes per beat
        logic [1:0]        burst;               // Burst type code
    } wbl_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0]     data;            // Write data, lane n in bits 8n+7:8n
        logic [DATA_BYTES-1:0] strb;            // One strobe per byte lane
    } wbl_beat_t;

endpackage

// ---- src/wbl_write_lanes.sv ----
// Purpose: Subordinate write-data end that steers burst beats onto byte lanes.
// Assumes: One clock; commands and beats are synchronous to it.
// Notes:   Storage is byte-invariant; a local read port can reorder big-endian elements.

// Operation
// (R01) One strobe per byte lane, high means valid
// (R02) Manager strobes only lanes holding valid data
// (R03) Ignore strobes while write valid is low
// (R04) Manager idles strobes low or held
// (R05) Narrow beat lanes from address and size
// (R06) Incr and wrap beats move lanes forward
// (R07) Fixed burst keeps same lanes every beat
// (R08) Five byte beats from zero: lanes 0-3-0
// (R09) Four-byte beats at 4, 64-bit: upper-lower-upper
// (R10) Byte address always uses same data wires
// (R11) Element keeps same bytes in either endianness
// (R12) Single-width storage wired lane to lane
// (R13) Big-endian access gets a byte reorder stage
// (R14) Big-endian: most significant byte lowest address
// (R15) Little-endian: least significant byte lowest address
// (R16) Accept unaligned starts for wide beats
// (R17) Manager may signal unaligned start by address
// (R18) Manager may signal unaligned start by strobes
// (R19) Manager keeps address and strobes consistent
// (R20) No special handling of alignment information
// (R21) Burst codes: fixed, incr, wrap, reserved
// (R22) Beat bytes two to the size, address step
// (R23) Later beat lanes from address modulo bus width
// (R24) Wrap back to boundary at boundary plus total
// (R25) Only strobed bytes update stored data
module wbl_write_lanes
    import wbl_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  cmd_valid,
    input  wire wbl_cmd_t              cmd,
    output logic                       cmd_ready_reg,
    input  wire logic                  wvalid,
    input  wire wbl_beat_t             wbeat,
    output logic                       wready_reg,
    output logic      [ADDR_W-1:0]     beat_addr_reg,
    output logic      [DATA_BYTES-1:0] lane_mask_reg,
    output logic                       strb_err_reg,
    output logic                       burst_done_reg,
    input  wire logic                  rd_en,
    input  wire logic [ADDR_W-1:0]     rd_addr,
    input  wire logic [1:0]            rd_size,
    input  wire logic                  rd_big,
    output logic      [DATA_W-1:0]     rd_data_reg,
    output logic                       rd_valid_reg
);

    // ************************************************************
    // Burst state
    // ************************************************************
    wbl_state_t        state_reg;               // Idle or in a burst
    logic [1:0]        burst_reg;               // Burst type of the open burst
    logic [1:0]        size_reg;                // Clamped size of the open burst
    logic [LEN_W-1:0]  left_reg;                // Beats remaining after this one
    logic [ADDR_W-1:0] wrap_lo_reg;             // Lowest address of a wrap burst
    logic [ADDR_W-1:0] wrap_hi_reg;             // Boundary plus total bytes

    // ************************************************************
    // Handshake decode
    // ************************************************************
    wire logic cmd_fire  = cmd_valid && cmd_ready_reg;
    // Strobes and data only count while write valid is high
    wire logic beat_fire = wvalid && wready_reg; // R03
    wire logic beat_last = (left_reg == RST_LEFT);

    // ************************************************************
    // Command decode
    // ************************************************************
    // Oversized beats are clamped to the bus width
    wire logic [1:0] cmd_size = (cmd.size > SIZE_MAX) ? SIZE_MAX[1:0] : cmd.size[1:0];
    // Total burst bytes: beats times bytes per beat
    wire logic [ADDR_W-1:0] cmd_total = ADDR_W'({1'b0, cmd.len} + 9'h001) << cmd_size;
    // Wrap boundary is the start aligned to the total size
    wire logic [ADDR_W-1:0] cmd_wlo   = cmd.addr & ~(cmd_total - 12'h001);
    wire logic [ADDR_W-1:0] cmd_whi   = cmd_wlo + cmd_total;

    // ************************************************************
    // Beat address advance
    // ************************************************************
    // Bytes per beat sets the step
    wire logic [ADDR_W-1:0] nb_cur    = 12'h001 << size_reg; // R22
    // Every incr or wrap beat after the first is aligned to the beat size
    wire logic [ADDR_W-1:0] align_cur = beat_addr_reg & ~(nb_cur - 12'h001); // R16 R20
    wire logic [ADDR_W-1:0] addr_inc  = align_cur + nb_cur; // R06
    wire logic              is_fixed  = (burst_reg == BURST_FIXED); // R21
    wire logic              is_wrap   = (burst_reg == BURST_WRAP); // R21
    wire logic              wrap_hit  = is_wrap && (addr_inc == wrap_hi_reg);
    // Fixed holds, wrap returns to the boundary, others step
    wire logic [ADDR_W-1:0] addr_adv  = is_fixed ? beat_addr_reg : // R07
                                        wrap_hit ? wrap_lo_reg :   // R24
                                        addr_inc;                  // R06
    wire logic [ADDR_W-1:0] addr_next = cmd_fire  ? cmd.addr :
                                        beat_fire ? addr_adv : beat_addr_reg;
    wire logic [1:0]        size_next = cmd_fire ? cmd_size : size_reg;

    // ************************************************************
    // Lane mask of the next beat address
    // ************************************************************
    logic [DATA_BYTES-1:0] mask_next;           // Lanes the next beat uses

    wbl_lane_mask u_lane_mask (
        .addr_lane (addr_next[LANE_W-1:0]),
        .size      (size_next),
        .mask      (mask_next)
    );

    // Strobes outside the expected lanes; flagged, never blocking
    wire logic strb_stray = beat_fire && (|(wbeat.strb & ~lane_mask_reg)); // R19

    // ************************************************************
    // Burst control
    // ************************************************************
    // Opens a burst on a command, closes it on the last counted beat
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg      <= WBL_IDLE;
            cmd_ready_reg  <= 1'b1;
            wready_reg     <= 1'b0;
            left_reg       <= RST_LEFT;
            burst_done_reg <= 1'b0;
        end else begin
            burst_done_reg <= 1'b0;
            case (state_reg)
                WBL_IDLE: begin
                    // Take a command and start accepting beats
                    if (cmd_fire) begin
                        state_reg     <= WBL_BURST;
                        cmd_ready_reg <= 1'b0;
                        wready_reg    <= 1'b1;
                        left_reg      <= cmd.len;
                    end
                end
                WBL_BURST: begin
                    // Count beats down; last one ends the burst
                    if (beat_fire) begin
                        if (beat_last) begin
                            state_reg      <= WBL_IDLE;
                            cmd_ready_reg  <= 1'b1;
                            wready_reg     <= 1'b0;
                            burst_done_reg <= 1'b1;
                        end else begin
                            left_reg <= left_reg - 8'h01;
                        end
                    end
                end
                default: begin
                    // Illegal code falls back to idle
                    state_reg     <= WBL_IDLE;
                    cmd_ready_reg <= 1'b1;
                    wready_reg    <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Address and lane registers
    // ************************************************************
    // Tracks the beat address and its lane mask together
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            beat_addr_reg <= RST_ADDR;
            lane_mask_reg <= RST_MASK;
            size_reg      <= 2'h0;
            strb_err_reg  <= 1'b0;
        end else begin
            beat_addr_reg <= addr_next;
            lane_mask_reg <= mask_next; // R05 R06 R07 R23
            size_reg      <= size_next;
            strb_err_reg  <= strb_stray;
        end
    end

    // Latches burst type and wrap bounds on command
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            burst_reg   <= BURST_INCR;
            wrap_lo_reg <= RST_ADDR;
            wrap_hi_reg <= RST_ADDR;
        end else if (cmd_fire) begin
            burst_reg   <= cmd.burst;
            wrap_lo_reg <= cmd_wlo;
            wrap_hi_reg <= cmd_whi;
        end
    end

    // ************************************************************
    // Byte-invariant storage, one array per lane
    // ************************************************************
    wire logic [WIDX_W-1:0] widx = beat_addr_reg[WIDX_LSB +: WIDX_W];
    wire logic [WIDX_W-1:0] ridx = rd_addr[WIDX_LSB +: WIDX_W];
    logic      [DATA_W-1:0] rd_word;            // Stored word at the read index

    genvar i;
    generate
        for (i = 0; i < DATA_BYTES; i++) begin : g_store
            logic [7:0] lane_mem [MEM_WORDS];   // Bytes that travel on lane i
            logic [7:0] old_q;                  // Byte before this cycle's write
            logic [7:0] new_q;                  // Data seen on the lane
            logic       wr_q;                   // Lane was written
            logic       hit_q;                  // A beat was taken
            logic [WIDX_W-1:0] idx_q;           // Index of that beat

            // Lane i of the bus always lands in byte i of storage
            always_ff @(posedge clock) begin
                if (beat_fire && wbeat.strb[i]) begin
                    lane_mem[widx] <= wbeat.data[8*i +: 8]; // R01 R10 R12 R25
                end
            end
            assign rd_word[8*i +: 8] = lane_mem[ridx]; // R10 R11

            // Helper history for the checks below
            always_ff @(posedge clock) begin
                old_q <= lane_mem[widx];
                new_q <= wbeat.data[8*i +: 8];
                wr_q  <= beat_fire && wbeat.strb[i];
                hit_q <= beat_fire;
                idx_q <= widx;
            end

            a_lane_write: assert property (@(posedge clock) disable iff (!rstn) // R01
                wr_q |-> lane_mem[idx_q] == new_q)
                else $error("strobed lane byte not stored");
            a_keep_unstrobed: assert property (@(posedge clock) disable iff (!rstn) // R25
                (hit_q && !wr_q) |-> lane_mem[idx_q] === old_q)
                else $error("unstrobed lane byte changed");
            a_ignore_idle: assert property (@(posedge clock) disable iff (!rstn) // R03
                (!wvalid ##1 1'b1) |-> lane_mem[idx_q] === old_q)
                else $error("byte changed with write valid low");
        end
    endgenerate

    // ************************************************************
    // Local read with endian reorder
    // ************************************************************
    wire logic [1:0]        rd_sz  = (rd_size == 2'h3) ? SIZE_MAX[1:0] : rd_size;
    wire logic [2:0]        rd_nb  = 3'h1 << rd_sz;
    wire logic [LANE_W-1:0] rd_m1  = LANE_W'(rd_nb - 3'h1);
    // Element starts at its aligned lane
    wire logic [LANE_W-1:0] rd_lo  = rd_addr[LANE_W-1:0] & ~rd_m1;
    logic      [DATA_W-1:0] rd_elem;            // Element, least significant byte first

    genvar k;
    generate
        for (k = 0; k < DATA_BYTES; k++) begin : g_elem
            // Big-endian takes bytes from the top of the element down
            wire logic [LANE_W-1:0] src_be = rd_lo + rd_m1 - LANE_W'(k); // R13 R14
            wire logic [LANE_W-1:0] src_le = rd_lo + LANE_W'(k);         // R15
            wire logic [LANE_W-1:0] src    = rd_big ? src_be : src_le;
            wire logic              in_elem = (3'(k) < rd_nb);
            assign rd_elem[8*k +: 8] = in_elem ? rd_word[8*src +: 8] : 8'h00; // R11
        end
    endgenerate

    // Registers the element one cycle after the request
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data_reg  <= RST_DATA;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en;
            if (rd_en) begin
                rd_data_reg <= rd_elem;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [DATA_W-1:0] rd_word_q;               // Word seen by the last read
    always_ff @(posedge clock) begin
        rd_word_q <= rd_word;
    end

    a_fixed_lanes: assert property (@(posedge clock) disable iff (!rstn) // R07
        (beat_fire && is_fixed && !beat_last) |=> $stable(lane_mask_reg))
        else $error("fixed burst changed lanes");
    a_step_aligned: assert property (@(posedge clock) disable iff (!rstn) // R06
        (beat_fire && !is_fixed && !wrap_hit && !beat_last) |=>
        (beat_addr_reg == $past(align_cur) + $past(nb_cur)) &&
        ((beat_addr_reg & (nb_cur - 12'h001)) == 12'h000))
        else $error("beat address did not step by beat size");
    a_wrap_bound: assert property (@(posedge clock) disable iff (!rstn) // R24
        (state_reg == WBL_BURST && is_wrap) |->
        (beat_addr_reg >= wrap_lo_reg) && (beat_addr_reg < wrap_hi_reg))
        else $error("wrap burst left its window");
    a_low_lane: assert property (@(posedge clock) disable iff (!rstn) // R23
        (state_reg == WBL_BURST) |->
        lane_mask_reg[beat_addr_reg[LANE_W-1:0]] &&
        ($countones(lane_mask_reg) <= int'(nb_cur)))
        else $error("lane mask does not start at beat lane");
    a_burst_end: assert property (@(posedge clock) disable iff (!rstn) // R08
        (beat_fire && beat_last) |=> burst_done_reg && cmd_ready_reg && !wready_reg)
        else $error("burst did not close on last beat");
    a_byte_incr: assert property (@(posedge clock) disable iff (!rstn) // R08
        (cmd_fire && cmd.addr == 12'h000 && cmd.size == 3'h0 && cmd.burst == BURST_INCR)
        |=> lane_mask_reg == 4'h1)
        else $error("first byte beat not on lane 0");
    a_big_swap: assert property (@(posedge clock) disable iff (!rstn) // R13
        (rd_en && rd_big && rd_sz == 2'h2) |=>
        rd_data_reg == {rd_word_q[7:0], rd_word_q[15:8], rd_word_q[23:16], rd_word_q[31:24]})
        else $error("big-endian word not reordered");
    a_little_pass: assert property (@(posedge clock) disable iff (!rstn) // R15
        (rd_en && !rd_big && rd_sz == 2'h2) |=> rd_data_reg == rd_word_q)
        else $error("little-endian word altered");

    c_incr_burst: cover property (@(posedge clock) disable iff (!rstn)
        beat_fire && burst_reg == BURST_INCR && beat_last);
    c_wrap_taken: cover property (@(posedge clock) disable iff (!rstn)
        beat_fire && wrap_hit);
    c_fixed_burst: cover property (@(posedge clock) disable iff (!rstn)
        beat_fire && is_fixed && !beat_last);
    c_unaligned: cover property (@(posedge clock) disable iff (!rstn)
        cmd_fire && cmd.size == 3'h2 && cmd.addr[1:0] != 2'h0);

endmodule

// ---- tb/tb_write_byte_lane_strobes.sv ----
// Purpose: Self-checking bench for the write byte-lane block.
// Assumes: Masks per beat are packed four bits a beat, first beat lowest.
// Notes:   Storage is checked only through the local read port.
module tb_write_byte_lane_strobes;
    import wbl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        wbl_cmd_t    c;                         // Burst command
        logic [19:0] m;                         // Expected lane masks
    } wbl_row_t;
    logic clock = 1'b0, rstn = 1'b0, junk = 1'b0, cmd_valid, wvalid, rd_en = 1'b0;
    logic rd_big = 1'b0, cmd_ready_reg, wready_reg, strb_err_reg, burst_done_reg, rd_valid_reg;
    logic [1:0] rd_size = 2'h0;
    logic [ADDR_W-1:0] rd_addr = 12'h000;
    logic [3:0] lane_mask_reg, em;
    logic [ADDR_W-1:0] beat_addr_reg;
    logic [DATA_W-1:0] rd_data_reg;
    wbl_cmd_t cmd;
    wbl_beat_t wbeat;
    logic [3:0] exp_q[$];
    logic took = 1'b0, err_exp = 1'b0;
    int mismatches = 0, tests_run = 0, cycles = 0, lo = 0;
    wbl_row_t rows[8] = '{
        '{'{12'h000, 8'h04, 3'h0, BURST_INCR},  20'h18421},
        '{'{12'h002, 8'h02, 3'h0, BURST_FIXED}, 20'h00444},
        '{'{12'h001, 8'h02, 3'h2, BURST_INCR},  20'h00FFE},
        '{'{12'h002, 8'h03, 3'h0, BURST_WRAP},  20'h02184},
        '{'{12'h002, 8'h02, 3'h1, BURST_INCR},  20'h00C3C},
        '{'{12'h004, 8'h01, 3'h0, 2'h3},        20'h00021},
        '{'{12'h008, 8'h01, 3'h3, BURST_INCR},  20'h000FF},
        '{'{12'h00E, 8'h01, 3'h1, BURST_WRAP},  20'h0003C}};
    always #5 clock = ~clock;
    wbl_mgr_model mdl (.clock(clock), .cmd_ready_reg(cmd_ready_reg), .wready_reg(wready_reg),
        .junk(junk), .cmd_valid(cmd_valid), .cmd(cmd), .wvalid(wvalid), .wbeat(wbeat));
    wbl_write_lanes dut_u (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready_reg(cmd_ready_reg), .wvalid(wvalid), .wbeat(wbeat),
        .wready_reg(wready_reg), .beat_addr_reg(beat_addr_reg), .lane_mask_reg(lane_mask_reg),
        .strb_err_reg(strb_err_reg), .burst_done_reg(burst_done_reg), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_size(rd_size), .rd_big(rd_big), .rd_data_reg(rd_data_reg),
        .rd_valid_reg(rd_valid_reg));
    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Beat monitor: lanes before each taken beat, error flag after it
    always @(negedge clock) begin
        if (took) check("strb_err", {31'h0, strb_err_reg}, {31'h0, err_exp});
        took = wvalid && wready_reg;
        if (took) begin
            em = exp_q.pop_front();
            check("lane_mask", {28'h0, lane_mask_reg}, {28'h0, em});
            err_exp = |(wbeat.strb & ~em);
            // Lowest expected lane must match the beat address within the bus word
            for (int b = DATA_BYTES - 1; b >= 0; b--) begin
                if (em[b]) lo = b;
            end
            check("beat_lane", {30'h0, beat_addr_reg[LANE_W-1:0]}, 32'(lo));
        end
    end
    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic burst(input wbl_cmd_t c, input logic [19:0] m, input logic [19:0] s,
                         input logic [31:0] d, input int gap);
        for (int i = 0; i <= int'(c.len); i++) exp_q.push_back(m[4*i +: 4]);
        mdl.send(c, s, d, gap);
        @(negedge clock);
        check("done", {30'h0, burst_done_reg, cmd_ready_reg}, 32'h3);
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] s, input logic b,
                      input logic [31:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        rd_addr <= a;
        rd_size <= s;
        rd_big <= b;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        check("rd_data", rd_data_reg, exp);
        check("rd_valid", {31'h0, rd_valid_reg}, 32'h1);
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        check("reset", {cmd_ready_reg, wready_reg, rd_valid_reg, lane_mask_reg}, 32'h40);
        @(posedge clock);
        rstn <= 1'b1;
        foreach (rows[i]) burst(rows[i].c, rows[i].m, rows[i].m, 32'h33221100 + i, 0);
        junk <= 1'b1;
        burst('{12'h040, 8'h00, 3'h2, BURST_INCR}, 20'hF, 20'hF, 32'h0A0B0C0D, 0);
        burst('{12'h041, 8'h00, 3'h0, BURST_INCR}, 20'h2, 20'h2, 32'hFFFFFFFF, 0);
        burst('{12'h048, 8'h00, 3'h0, BURST_INCR}, 20'h1, 20'h2, 32'h0, 0);
        burst('{12'h050, 8'h02, 3'h2, BURST_INCR}, 20'hFFF, 20'hFFF, 32'h87654321, 2);
        burst('{12'h060, 8'h00, 3'h2, BURST_INCR}, 20'hF, 20'hE, 32'h0A0B0C0D, 0);
        rd(12'h040, 2'h2, 1'b0, 32'h0A0BFF0D);
        rd(12'h040, 2'h2, 1'b1, 32'h0DFF0B0A);
        rd(12'h042, 2'h1, 1'b1, 32'h00000B0A);
        rd(12'h042, 2'h1, 1'b0, 32'h00000A0B);
        rd(12'h054, 2'h2, 1'b0, 32'h87654321);
        rd(12'h061, 2'h0, 1'b0, 32'h0000000C);
        wrap_up();
    end
endmodule

// ---- tb/wbl_mgr_model.sv ----
// Purpose: Manager model that issues burst commands and write beats.
// Assumes: Handshakes are sampled on the falling edge before the taking edge.
// Notes:   junk high drives stray strobes while write valid is low.
module wbl_mgr_model
    import wbl_pkg::*;
(
    input  wire logic clock,
    input  wire logic cmd_ready_reg,
    input  wire logic wready_reg,
    input  wire logic junk,
    output logic      cmd_valid,
    output wbl_cmd_t  cmd,
    output logic      wvalid,
    output wbl_beat_t wbeat
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Burst driver
    // ************************************************************
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        wvalid = 1'b0;
        wbeat = '0;
    end
    // One command, then len+1 beats held until taken
    task automatic send(input wbl_cmd_t c, input logic [19:0] strbs,
                        input logic [31:0] d, input int gap);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd <= c;
        do @(negedge clock); while (cmd_ready_reg !== 1'b1);
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (int i = 0; i <= int'(c.len); i++) begin
            wvalid <= 1'b1;
            wbeat <= {d, strbs[4*i +: 4]};
            do @(negedge clock); while (wready_reg !== 1'b1);
            @(posedge clock);
            if (gap > 0 || i == int'(c.len)) begin
                wvalid <= 1'b0;
                // Idle strobes low unless stray ones are asked for
                wbeat <= junk ? {32'h55555555, 4'hF} : {d, 4'h0};
                if (i < int'(c.len)) repeat (gap) @(posedge clock);
            end
        end
    endtask
endmodule
